// File: rtl/uiic_params.svh
/*
 * constants of the interrupt-identification / fifo-control block:
 * register offsets, field positions, reset values.
 * assumes inclusion by bare name from the block's design files.
 */
`ifndef UIIC_PARAMS_SVH
`define UIIC_PARAMS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define UIIC_OFS_CTRL 5'h00
`define UIIC_OFS_STATUS 5'h04
`define UIIC_OFS_MASK 5'h08
`define UIIC_OFS_CFG 5'h0c

// ------------------------------------------------------------
// control word fields (write side)
// ------------------------------------------------------------
`define UIIC_CTRL_FIFO_EN 0
`define UIIC_CTRL_RX_RST 1
`define UIIC_CTRL_TX_RST 2
`define UIIC_CTRL_DMA_MODE 3
// read side: fifo state pair at bits 7:6
`define UIIC_CTRL_FIFO_STATE 6

// ------------------------------------------------------------
// event bits, shared by status and mask
// ------------------------------------------------------------
`define UIIC_NUM_EV 5
`define UIIC_EV_LINE 0
`define UIIC_EV_RXDATA 1
`define UIIC_EV_TIMEOUT 2
`define UIIC_EV_THRE 3
`define UIIC_EV_BUSY 4

// ------------------------------------------------------------
// dma channels and reset values
// ------------------------------------------------------------
`define UIIC_CH_TX 0
`define UIIC_CH_RX 1
`define UIIC_RST_FIFO_EN 1'b0
`define UIIC_RST_DMA_MODE 1'b0
`define UIIC_RST_MASK 5'h00

`endif

// File: rtl/uiic_pkg.sv
/*
 * types of the interrupt-identification / fifo-control block.
 * assumes nothing; every user names items as uiic_pkg::name.
 */
package uiic_pkg;

   // bus handshake states, gray along idle -> ack -> idle
   typedef enum logic [1:0] {
      UIIC_ST_IDLE = 2'h0,
      UIIC_ST_ACK = 2'h1
   } uiic_bus_st_t;

   // four-bit pending interrupt code
   typedef enum logic [3:0] {
      UIIC_IRQ_NONE = 4'h1,
      UIIC_IRQ_THRE = 4'h2,
      UIIC_IRQ_RXDATA = 4'h4,
      UIIC_IRQ_LINE = 4'h6,
      UIIC_IRQ_BUSY = 4'h7,
      UIIC_IRQ_TIMEOUT = 4'hc
   } uiic_irq_code_t;

   // dma request signalling modes
   typedef enum logic {
      UIIC_DMA_MODE0 = 1'b0,
      UIIC_DMA_MODE1 = 1'b1
   } uiic_dma_mode_t;

endpackage

// File: rtl/uiic_src_if.sv
/*
 * carrier between the control top and the priority encoder:
 * pending source levels out, winning code back.
 * assumes the sources are levels synchronous to the one clock.
 */
`timescale 1ns/1ns
`include "uiic_params.svh"

interface uiic_src_if;
   logic [`UIIC_NUM_EV-1:0] pending;
   uiic_pkg::uiic_irq_code_t pending_irq_code;

   modport ctl (output pending, input pending_irq_code);
   modport enc (input pending, output pending_irq_code);
endinterface

// File: rtl/uiic_prio_enc.sv
/*
 * priority encoder: one pending code out of the five sources.
 * assumes the pending vector is driven by the control top.
 */
`timescale 1ns/1ns
`include "uiic_params.svh"

module uiic_prio_enc (
   uiic_src_if.enc src
);
   // ------------------------------------------------------------
   // encoder
   // ------------------------------------------------------------
   // only the winner is reported; lower sources wait their turn
   always_comb begin
      if (src.pending[`UIIC_EV_LINE]) begin
         src.pending_irq_code = uiic_pkg::UIIC_IRQ_LINE;
      end else if (src.pending[`UIIC_EV_RXDATA]) begin
         src.pending_irq_code = uiic_pkg::UIIC_IRQ_RXDATA;
      end else if (src.pending[`UIIC_EV_TIMEOUT]) begin
         src.pending_irq_code = uiic_pkg::UIIC_IRQ_TIMEOUT;
      end else if (src.pending[`UIIC_EV_THRE]) begin
         src.pending_irq_code = uiic_pkg::UIIC_IRQ_THRE;
      end else if (src.pending[`UIIC_EV_BUSY]) begin
         src.pending_irq_code = uiic_pkg::UIIC_IRQ_BUSY;
      end else begin
         src.pending_irq_code = uiic_pkg::UIIC_IRQ_NONE;
      end
   end
endmodule // uiic_prio_enc

// File: rtl/uiic_self_clear.sv
/*
 * self-clearing request: the trigger registered, so a one-cycle trigger gives a one-cycle pulse.
 * assumes the trigger is synchronous to clock.
 */
`timescale 1ns/1ns

module uiic_self_clear #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [W-1:0] trig,
   output logic [W-1:0] pulse_ff
);
   logic [W-1:0] nxt_pulse;

   // ------------------------------------------------------------
   // pulse
   // ------------------------------------------------------------
   // high in each cycle that follows a cycle with the trigger high, low otherwise
   always_comb begin
      nxt_pulse = trig;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pulse_ff <= '0;
      end else begin
         pulse_ff <= nxt_pulse;
      end
   end
endmodule // uiic_self_clear

// File: rtl/uiic_ctrl.sv
/*
 * interrupt identification and fifo control word of a serial port,
 * with avalon-mm slave, sticky event status, mask and dma requests.
 * assumes all inputs are synchronous to clock; the fifos and the
 * shifter live outside and obey the reset pulses given here.
 */
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "uiic_params.svh"

module uiic_ctrl (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic src_line_status,
   input wire logic src_rx_data,
   input wire logic src_char_timeout,
   input wire logic src_thr_empty,
   input wire logic src_busy_detect,
   input wire logic dma_tx_want,
   input wire logic dma_rx_want,
   input wire logic dma_tx_ack,
   input wire logic dma_rx_ack,
   output logic dma_tx_req_n,
   output logic dma_rx_req_n,
   output logic fifo_enable_ctl,
   output logic tx_fifo_reset_req,
   output logic rx_fifo_reset_req,
   output logic irq
);
   uiic_src_if src ();

   uiic_pkg::uiic_bus_st_t state_ff, nxt_state;
   logic wait_ff, nxt_wait;
   logic [31:0] rdata_ff, nxt_rdata;
   logic fifo_en_ff, nxt_fifo_en;
   uiic_pkg::uiic_dma_mode_t dma_mode_ff, nxt_dma_mode;
   logic [`UIIC_NUM_EV-1:0] status_ff, nxt_status;
   logic [`UIIC_NUM_EV-1:0] mask_ff, nxt_mask;
   logic [`UIIC_NUM_EV-1:0] src_q_ff, nxt_src_q;
   logic irq_ff, nxt_irq;
   logic [1:0] hold_ff, nxt_hold;
   logic [1:0] req_n_ff, nxt_req_n;
   logic [1:0] want, ack, rst_trig, rst_pulse;
   logic accept, wr_ctrl, rd_status;

   // ------------------------------------------------------------
   // sources and encoder
   // ------------------------------------------------------------
   assign src.pending = {src_busy_detect, src_thr_empty, src_char_timeout, src_rx_data, src_line_status};

   uiic_prio_enc u_enc (
      .src(src.enc)
   );

   // ------------------------------------------------------------
   // avalon handshake
   // ------------------------------------------------------------
   // one wait cycle: request seen in idle, taken in ack when waitrequest is low
   assign accept = (avs_read | avs_write) & (state_ff == uiic_pkg::UIIC_ST_ACK);
   assign wr_ctrl = accept & avs_write & (avs_address == `UIIC_OFS_CTRL);
   assign rd_status = accept & avs_read & (avs_address == `UIIC_OFS_STATUS);

   always_comb begin
      nxt_state = state_ff;
      nxt_rdata = rdata_ff;
      case (state_ff)
         uiic_pkg::UIIC_ST_IDLE: begin
            if (avs_read | avs_write) begin
               nxt_state = uiic_pkg::UIIC_ST_ACK;
               // snapshot at request time; unmapped reads give zero
               case (avs_address)
                  `UIIC_OFS_CTRL: begin
                     nxt_rdata = {24'h0, {2{fifo_en_ff}}, 2'h0, 4'(src.pending_irq_code)};
                  end
                  `UIIC_OFS_STATUS: begin
                     nxt_rdata = {27'h0, status_ff};
                  end
                  `UIIC_OFS_MASK: begin
                     nxt_rdata = {27'h0, mask_ff};
                  end
                  `UIIC_OFS_CFG: begin
                     nxt_rdata = {30'h0, dma_mode_ff, fifo_en_ff};
                  end
                  default: begin
                     nxt_rdata = 32'h0;
                  end
               endcase
            end
         end
         uiic_pkg::UIIC_ST_ACK: begin
            nxt_state = uiic_pkg::UIIC_ST_IDLE;
         end
         default: begin
            nxt_state = uiic_pkg::UIIC_ST_IDLE;
         end
      endcase
      nxt_wait = (nxt_state != uiic_pkg::UIIC_ST_ACK);
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= uiic_pkg::UIIC_ST_IDLE;
         wait_ff <= 1'b1;
         rdata_ff <= 32'h0;
      end else begin
         state_ff <= nxt_state;
         wait_ff <= nxt_wait;
         rdata_ff <= nxt_rdata;
      end
   end

   assign avs_waitrequest = wait_ff;
   assign avs_readdata = rdata_ff;

   // ------------------------------------------------------------
   // control and configuration
   // ------------------------------------------------------------
   // reset bits are never stored: they only fire the pulse module
   always_comb begin
      nxt_fifo_en = fifo_en_ff;
      nxt_dma_mode = dma_mode_ff;
      nxt_mask = mask_ff;
      rst_trig = 2'h0;
      if (wr_ctrl) begin
         nxt_fifo_en = avs_writedata[`UIIC_CTRL_FIFO_EN];
         nxt_dma_mode = uiic_pkg::uiic_dma_mode_t'(avs_writedata[`UIIC_CTRL_DMA_MODE]);
         rst_trig[`UIIC_CH_TX] = avs_writedata[`UIIC_CTRL_TX_RST];
         rst_trig[`UIIC_CH_RX] = avs_writedata[`UIIC_CTRL_RX_RST];
         if (avs_writedata[`UIIC_CTRL_FIFO_EN] != fifo_en_ff) begin
            rst_trig = 2'h3;
         end
      end
      if (accept & avs_write & (avs_address == `UIIC_OFS_MASK)) begin
         nxt_mask = avs_writedata[`UIIC_NUM_EV-1:0];
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         fifo_en_ff <= `UIIC_RST_FIFO_EN;
         dma_mode_ff <= uiic_pkg::uiic_dma_mode_t'(`UIIC_RST_DMA_MODE);
         mask_ff <= `UIIC_RST_MASK;
      end else begin
         fifo_en_ff <= nxt_fifo_en;
         dma_mode_ff <= nxt_dma_mode;
         mask_ff <= nxt_mask;
      end
   end

   // both channels share one pulse module, one bit each
   uiic_self_clear #(
      .W(2)
   ) u_rst (
      .clock(clock),
      .reset_n(reset_n),
      .trig(rst_trig),
      .pulse_ff(rst_pulse)
   );

   assign fifo_enable_ctl = fifo_en_ff;
   assign tx_fifo_reset_req = rst_pulse[`UIIC_CH_TX];
   assign rx_fifo_reset_req = rst_pulse[`UIIC_CH_RX];

   // ------------------------------------------------------------
   // sticky events and interrupt
   // ------------------------------------------------------------
   // rising edges set; a read clears only what it returned, so a set
   // landing between snapshot and clear survives
   always_comb begin
      nxt_src_q = src.pending;
      nxt_status = status_ff;
      if (rd_status) begin
         nxt_status = status_ff & ~rdata_ff[`UIIC_NUM_EV-1:0];
      end
      nxt_status = nxt_status | (src.pending & ~src_q_ff);
      nxt_irq = |(status_ff & mask_ff);
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         src_q_ff <= '0;
         status_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         src_q_ff <= nxt_src_q;
         status_ff <= nxt_status;
         irq_ff <= nxt_irq;
      end
   end

   assign irq = irq_ff;

   // ------------------------------------------------------------
   // dma requests
   // ------------------------------------------------------------
   // mode 0 follows the fifo condition; mode 1 latches until acked,
   // and a fifo reset drops a latched request of its channel
   assign want = {dma_rx_want, dma_tx_want};
   assign ack = {dma_rx_ack, dma_tx_ack};

   always_comb begin
      nxt_hold = hold_ff;
      nxt_req_n = 2'h3;
      for (int ch = 0; ch < 2; ch++) begin
         if (rst_pulse[ch] | ack[ch]) begin
            nxt_hold[ch] = 1'b0;
         end else if (want[ch]) begin
            nxt_hold[ch] = 1'b1;
         end
         if (dma_mode_ff == uiic_pkg::UIIC_DMA_MODE0) begin
            nxt_req_n[ch] = ~want[ch];
         end else begin
            nxt_req_n[ch] = ~nxt_hold[ch];
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         hold_ff <= 2'h0;
         req_n_ff <= 2'h3;
      end else begin
         hold_ff <= nxt_hold;
         req_n_ff <= nxt_req_n;
      end
   end

   assign dma_tx_req_n = req_n_ff[`UIIC_CH_TX];
   assign dma_rx_req_n = req_n_ff[`UIIC_CH_RX];

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   // one clock for all; reset forces every flop, so the checks rest then
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   sequence s_rd_ctrl_seen;
      avs_read && state_ff == uiic_pkg::UIIC_ST_IDLE && avs_address == `UIIC_OFS_CTRL;
   endsequence

   sequence s_taken;
      !avs_waitrequest;
   endsequence

   // mode 1 over two edges, so the registered request already obeys it
   sequence s_mode1_steady;
      dma_mode_ff == uiic_pkg::UIIC_DMA_MODE1 && $past(dma_mode_ff) == uiic_pkg::UIIC_DMA_MODE1;
   endsequence

   a_read_code_word: assert property (s_rd_ctrl_seen ##1 s_taken |->
      avs_readdata[3:0] == $past(src.pending_irq_code))
      else $error("read code differs from code at request");
   a_read_fifo_state: assert property (s_rd_ctrl_seen ##1 s_taken |->
      avs_readdata[7:4] == {{2{$past(fifo_enable_ctl)}}, 2'h0})
      else $error("fifo state bits of the code word wrong");
   a_idle_code_none: assert property (src.pending == '0 |->
      src.pending_irq_code == uiic_pkg::UIIC_IRQ_NONE)
      else $error("code not none with nothing pending");
   a_line_status_wins: assert property (src_line_status |-> src.pending_irq_code == 4'h6)
      else $error("line status not reported first");
   a_busy_lowest: assert property (src.pending == 5'h10 |-> src.pending_irq_code == 4'h7)
      else $error("busy alone not reported");
   a_dma_mode0_level: assert property (dma_mode_ff == uiic_pkg::UIIC_DMA_MODE0
      && $stable(dma_mode_ff) |=> dma_tx_req_n == !$past(dma_tx_want))
      else $error("mode 0 request does not follow condition");
   a_mode1_tx_hold: assert property (s_mode1_steady ##0
      (!dma_tx_req_n && !dma_tx_ack && !tx_fifo_reset_req) |=> !dma_tx_req_n)
      else $error("mode 1 tx request dropped without ack");
   a_mode1_rx_drop: assert property (s_mode1_steady ##0
      (dma_rx_ack || rx_fifo_reset_req) |=> dma_rx_req_n)
      else $error("mode 1 rx request kept after ack or reset");
   a_mode1_tx_drop: assert property (s_mode1_steady ##0
      (dma_tx_ack || tx_fifo_reset_req) |=> dma_tx_req_n)
      else $error("mode 1 tx request kept after ack or reset");
   a_tx_reset_pulse: assert property (wr_ctrl && avs_writedata[`UIIC_CTRL_TX_RST]
      |=> tx_fifo_reset_req ##1 !tx_fifo_reset_req)
      else $error("tx fifo reset pulse wrong");
   a_rx_reset_pulse: assert property (wr_ctrl && avs_writedata[`UIIC_CTRL_RX_RST]
      |=> rx_fifo_reset_req)
      else $error("rx fifo reset pulse missing");
   a_pulse_self_clear: assert property (tx_fifo_reset_req |-> $past(rst_trig[`UIIC_CH_TX]))
      else $error("tx reset held without trigger");
   a_rx_self_clear: assert property (rx_fifo_reset_req |-> $past(rst_trig[`UIIC_CH_RX]))
      else $error("rx reset held without trigger");
   a_enable_change_rst: assert property (wr_ctrl && avs_writedata[`UIIC_CTRL_FIFO_EN] != fifo_en_ff
      |=> tx_fifo_reset_req && rx_fifo_reset_req && fifo_enable_ctl == $past(avs_writedata[`UIIC_CTRL_FIFO_EN]))
      else $error("enable change did not reset both fifos");
   a_wait_one_cycle: assert property ((avs_read || avs_write) && state_ff == uiic_pkg::UIIC_ST_IDLE
      |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("waitrequest not low for one cycle");
endmodule // uiic_ctrl

// File: verif/uiic_dma_host.sv
/*
 * model of the dma controller facing one active-low request line.
 * assumes the request is registered on the same clock; the ack is a
 * one-cycle pulse, given delay cycles after the request is seen low.
 */
`timescale 1ns/1ns

module uiic_dma_host (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic req_n,
   input wire logic ack_on,
   input wire logic [3:0] delay,
   output logic ack
);
   logic [3:0] cnt_ff;

   // ------------------------------------------------------------
   // ack timing
   // ------------------------------------------------------------
   // the ack term keeps a delay of 0 from double-acking, since req_n rises one cycle late
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= 4'h0;
         ack <= 1'b0;
      end else begin
         ack <= 1'b0;
         if (req_n || !ack_on || ack) begin
            cnt_ff <= 4'h0;
         end else if (cnt_ff == delay) begin
            ack <= 1'b1;
            cnt_ff <= 4'h0;
         end else begin
            cnt_ff <= cnt_ff + 4'h1;
         end
      end
   end
endmodule // uiic_dma_host

// File: verif/uart_irq_id_fifo_ctrl_test.sv
/*
 * self-checking bench of the interrupt-identification / fifo-control block.
 * assumes the design files and the dma host model are compiled first.
 */
`timescale 1ns/1ns

module uart_irq_id_fifo_ctrl_test;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [4:0] src = 5'h00;
   logic [1:0] want = 2'h0;
   logic [1:0] ack;
   logic [1:0] req_n;
   logic ack_on = 1'b0;
   logic fifo_enable_ctl;
   logic tx_fifo_reset_req;
   logic rx_fifo_reset_req;
   logic irq;
   logic [31:0] q;
   int error_cnt = 0;
   int comparisons = 0;
   int tx_pulses = 0;
   int rx_pulses = 0;
   int t0;
   int r0;

   // ------------------------------------------------------------
   // clock, design and dma host models
   // ------------------------------------------------------------
   always #2 clock = ~clock;

   uiic_ctrl DUT (.clock(clock), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .src_line_status(src[0]), .src_rx_data(src[1]),
      .src_char_timeout(src[2]), .src_thr_empty(src[3]), .src_busy_detect(src[4]),
      .dma_tx_want(want[0]), .dma_rx_want(want[1]), .dma_tx_ack(ack[0]), .dma_rx_ack(ack[1]),
      .dma_tx_req_n(req_n[0]), .dma_rx_req_n(req_n[1]), .fifo_enable_ctl(fifo_enable_ctl),
      .tx_fifo_reset_req(tx_fifo_reset_req), .rx_fifo_reset_req(rx_fifo_reset_req), .irq(irq));

   // tx side answers fast, rx side slow
   uiic_dma_host tx_host (.clock(clock), .reset_n(reset_n), .req_n(req_n[0]), .ack_on(ack_on),
      .delay(4'h1), .ack(ack[0]));
   uiic_dma_host rx_host (.clock(clock), .reset_n(reset_n), .req_n(req_n[1]), .ack_on(ack_on),
      .delay(4'h5), .ack(ack[1]));

   // count cycles each reset request is high; a stuck request shows as >1
   always @(posedge clock) begin
      if (tx_fifo_reset_req === 1'b1) tx_pulses++;
      if (rx_fifo_reset_req === 1'b1) rx_pulses++;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // priority: line, rx data, timeout, tx holding empty, busy
   function automatic logic [3:0] exp_code(input logic [4:0] s);
      if (s[0]) return 4'h6;
      if (s[1]) return 4'h4;
      if (s[2]) return 4'hc;
      if (s[3]) return 4'h2;
      if (s[4]) return 4'h7;
      return 4'h1;
   endfunction

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one avalon transfer; held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] rd);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge clock);
      // no local limit: a slave that never answers is caught by the watchdog
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clock);
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   endtask

   task automatic give_verdict;
      if (error_cnt == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // watchdog, far beyond the ~320 cycles the tests need
   // ------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      give_verdict();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'he6c0));
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      repeat (2) @(posedge clock);
      chk("dma_req_n", {30'h0, req_n}, 32'h3);
      chk("fifo_enable_ctl", {31'h0, fifo_enable_ctl}, 32'h0);
      // single sources, none, rx+timeout tie, then random mixes
      for (int i = 0; i < 40; i++) begin
         src <= (i < 5) ? (5'h01 << i) : (i == 5) ? 5'h00 : (i == 6) ? 5'h06 : 5'($urandom);
         repeat (2) @(posedge clock);
         bus(1'b0, 5'h00, 32'h0, q);
         chk("irq_code", q, {28'h0, exp_code(src)});
      end
      // tx reset, rx reset, enable change, enable rewrite without change
      for (int i = 0; i < 4; i++) begin
         t0 = tx_pulses;
         r0 = rx_pulses;
         bus(1'b1, 5'h00, {28'h0, 4'(16'h1124 >> (4 * i))}, q);
         repeat (3) @(posedge clock);
         chk("tx_reset_pulses", 32'(tx_pulses - t0), {31'h0, 1'(4'b0101 >> i)});
         chk("rx_reset_pulses", 32'(rx_pulses - r0), {31'h0, 1'(4'b0110 >> i)});
      end
      chk("fifo_enable_ctl", {31'h0, fifo_enable_ctl}, 32'h1);
      bus(1'b0, 5'h00, 32'h0, q);
      chk("ctrl_read", q, {24'h0, 4'hc, exp_code(src)});
      // mode zero follows want level
      want <= 2'h3;
      repeat (3) @(posedge clock);
      chk("dma_req_n", {30'h0, req_n}, 32'h0);
      want <= 2'h0;
      repeat (3) @(posedge clock);
      chk("dma_req_n", {30'h0, req_n}, 32'h3);
      // mode one holds the request until acked
      bus(1'b1, 5'h00, 32'h9, q);
      want <= 2'h3;
      @(posedge clock);
      want <= 2'h0;
      repeat (6) @(posedge clock);
      chk("dma_req_n", {30'h0, req_n}, 32'h0);
      ack_on <= 1'b1;
      repeat (12) @(posedge clock);
      chk("dma_req_n", {30'h0, req_n}, 32'h3);
      // a tx fifo reset drops a pending tx request
      ack_on <= 1'b0;
      want <= 2'h1;
      @(posedge clock);
      want <= 2'h0;
      repeat (3) @(posedge clock);
      chk("dma_req_n", {30'h0, req_n}, 32'h2);
      bus(1'b1, 5'h00, 32'hd, q);
      repeat (3) @(posedge clock);
      chk("dma_req_n", {30'h0, req_n}, 32'h3);
      // sticky status, mask and level interrupt
      src <= 5'h00;
      repeat (2) @(posedge clock);
      bus(1'b0, 5'h04, 32'h0, q);
      bus(1'b1, 5'h08, 32'h2, q);
      bus(1'b0, 5'h08, 32'h0, q);
      chk("mask", q, 32'h2);
      src <= 5'h08;
      repeat (3) @(posedge clock);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      src <= 5'h0a;
      repeat (3) @(posedge clock);
      chk("irq_set", {31'h0, irq}, 32'h1);
      bus(1'b0, 5'h04, 32'h0, q);
      chk("status", q, 32'ha);
      repeat (2) @(posedge clock);
      chk("irq_cleared", {31'h0, irq}, 32'h0);
      bus(1'b0, 5'h04, 32'h0, q);
      chk("status_cleared", q, 32'h0);
      // unmapped place reads zero
      bus(1'b1, 5'h10, 32'hffffffff, q);
      bus(1'b0, 5'h10, 32'h0, q);
      chk("unmapped", q, 32'h0);
      // cfg word, then a reset in mid-run must bring back the reset values
      bus(1'b0, 5'h0c, 32'h0, q);
      chk("cfg", q, 32'h3);
      reset_n <= 1'b0;
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      repeat (2) @(posedge clock);
      chk("fifo_enable_ctl", {31'h0, fifo_enable_ctl}, 32'h0);
      chk("dma_req_n", {30'h0, req_n}, 32'h3);
      bus(1'b0, 5'h0c, 32'h0, q);
      chk("cfg_after_reset", q, 32'h0);
      give_verdict();
   end
endmodule // uart_irq_id_fifo_ctrl_test
